/* hdl/cdt_consts.vh */
// Constants for the channel diagnostic and timestamp block
`ifndef CDT_CONSTS_VH
`define CDT_CONSTS_VH
`define CDT_NUM_CH        8
`define CDT_ERR_PARAM_BIT 0
`define CDT_ERR_WIRE_BIT  4
`define CDT_MOD_CHANNEL_ERROR_SUMMARY_BIT 3
`define CDT_ERR_RESET     8'h00
`define CDT_TS_RESET      32'h0000_0000
`define CDT_CLK_MHZ       250
`define CDT_TICK_NS       1000
`define CDT_CLK_NS        4
`define CDT_TICK_CYCLES   (`CDT_TICK_NS / `CDT_CLK_NS)
`endif

/* hdl/cdt_us_ticker.v */
// Free-running 32-bit microsecond counter with prescaler
`default_nettype none
`include "cdt_consts.vh"
module cdt_us_ticker #(
    parameter integer TICK_CYCLES = `CDT_TICK_CYCLES
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    output reg  [31:0] us_count_q
);
    // Prescaler position within one microsecond
    reg [15:0] pre_q;
    wire       tick = (pre_q == TICK_CYCLES[15:0] - 16'h0001);

    // Prescaler gives a one-cycle pulse each microsecond
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 16'h0000;
        end else if (tick) begin
            pre_q <= 16'h0000; // [R10]
        end else begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    // Counter starts at zero and wraps naturally past all ones
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            us_count_q <= `CDT_TS_RESET; // [R5]
        end else if (tick) begin
            us_count_q <= us_count_q + 32'h0000_0001; // [R4] [R6]
        end
    end
endmodule // cdt_us_ticker
`default_nettype wire

/* hdl/cdt_channel_diag.v */
// Per-channel diagnostic bytes with microsecond timestamp capture
// Notes on behaviour
// [R1] Channel byte bit 0 flags parameterization error
// [R2] Channel byte bit 4 flags wire break
// [R3] Four-byte timestamp latched at diagnostic event
// [R4] 32-bit counter advances once per microsecond
// [R5] Counter is zero at power-on, counts up
// [R6] Counter wraps to zero and keeps running
// [R7] Summary bit n set while channel n errs
// [R8] Wire break monitored only when enabled
// [R9] Module diagnostic bit 3 on any channel error
// [R10] Prescaled tick; reserved channel bits read zero
`default_nettype none
`include "cdt_consts.vh"
module cdt_channel_diag #(
    parameter integer NUM_CH      = `CDT_NUM_CH,
    parameter integer TICK_CYCLES = `CDT_TICK_CYCLES
) (
    input  wire                ref_clk,
    input  wire                rst_n,
    input  wire [NUM_CH-1:0]   param_error,
    input  wire [NUM_CH-1:0]   wire_break_raw,
    input  wire [NUM_CH-1:0]   wire_break_enable,
    input  wire [2:0]          channel_select,
    output reg  [7:0]          channel_error_detail,
    output reg  [NUM_CH-1:0]   channel_error_summary,
    output reg  [7:0]          module_diag,
    output reg  [31:0]         diagnostic_timestamp,
    output reg                 diag_event,
    output wire [31:0]         us_count
);
    // Three-stage synchroniser on pin-level wire break inputs
    reg [NUM_CH-1:0] wb_s1_q;
    reg [NUM_CH-1:0] wb_s2_q;
    reg [NUM_CH-1:0] wb_s3_q;
    reg [NUM_CH-1:0] wb_q;       // Filtered level, changes when stages agree
    reg [NUM_CH-1:0] err_prev_q; // Error vector last cycle, for event edge
    reg [7:0]        err_byte_q [0:NUM_CH-1]; // Per-channel detail storage
    wire [NUM_CH-1:0] ch_err;
    integer i;

    // Timestamp source
    cdt_us_ticker #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_ticker (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .us_count_q (us_count)
    );

    // Synchroniser; first stage feeds only the second
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_s1_q <= {NUM_CH{1'b0}};
            wb_s2_q <= {NUM_CH{1'b0}};
            wb_s3_q <= {NUM_CH{1'b0}};
            wb_q    <= {NUM_CH{1'b0}};
        end else begin
            wb_s1_q <= wire_break_raw;
            wb_s2_q <= wb_s1_q;
            wb_s3_q <= wb_s2_q;
            // Change only once stages two and three agree, rejecting glitches
            wb_q    <= (wb_s2_q & wb_s3_q) | (wb_q & (wb_s2_q | wb_s3_q));
        end
    end

    // Any error per channel; a disabled channel never reports a break
    assign ch_err = param_error | (wb_q & wire_break_enable); // [R8]

    // Build detail bytes; reserved bits stay zero
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < NUM_CH; i = i + 1) begin
                err_byte_q[i] <= `CDT_ERR_RESET;
            end
        end else begin
            for (i = 0; i < NUM_CH; i = i + 1) begin
                err_byte_q[i] <= `CDT_ERR_RESET; // [R10]
                err_byte_q[i][`CDT_ERR_PARAM_BIT] <= param_error[i]; // [R1]
                err_byte_q[i][`CDT_ERR_WIRE_BIT]  <= wb_q[i] & wire_break_enable[i]; // [R2] [R8]
            end
        end
    end

    // Summary, module byte, event detection and timestamp capture
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            channel_error_summary <= {NUM_CH{1'b0}};
            module_diag           <= 8'h00;
            err_prev_q            <= {NUM_CH{1'b0}};
            diag_event            <= 1'b0;
            diagnostic_timestamp  <= `CDT_TS_RESET;
            channel_error_detail  <= `CDT_ERR_RESET;
        end else begin
            channel_error_summary <= ch_err; // [R7]
            module_diag <= 8'h00;
            module_diag[`CDT_MOD_CHANNEL_ERROR_SUMMARY_BIT] <= |ch_err; // [R9]
            err_prev_q <= ch_err;
            // New error on any channel is a diagnostic event
            diag_event <= |(ch_err & ~err_prev_q);
            if (|(ch_err & ~err_prev_q)) begin
                diagnostic_timestamp <= us_count; // [R3]
            end
            // Selected channel presented for readout
            channel_error_detail <= err_byte_q[channel_select];
        end
    end
endmodule // cdt_channel_diag
`default_nettype wire

/* tb/cdt_diag_props_properties.sv */
// Port assertions for the channel diagnostic block
`default_nettype none
module cdt_diag_props #(parameter integer TICK_CYCLES = 4) (
    input wire logic ref_clk, rst_n, input wire logic [7:0] param_error, wire_break_raw,
    input wire logic [7:0] wire_break_enable, channel_error_detail, channel_error_summary,
    input wire logic [7:0] module_diag, input wire logic [2:0] channel_select,
    input wire logic diag_event, input wire logic [31:0] diagnostic_timestamp, us_count);
    timeunit 1ns; timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_MOD: assert property (module_diag == {4'h0, |channel_error_summary, 3'h0})
        else $error("module byte bad");
    AST_SUM: assert property ((channel_error_summary & $past(param_error)) == $past(param_error))
        else $error("summary bad");
    AST_DET: assert property ({7'h0, channel_error_detail[0]} ==
        (($past(param_error, 2) >> $past(channel_select)) & 8'h01)) else $error("detail bad");
    AST_RSV: assert property ((channel_error_detail & 8'hEE) == 8'h00) else $error("rsv set");
    AST_TS: assert property (diag_event |-> diagnostic_timestamp == $past(us_count))
        else $error("stamp bad");
    AST_HOLD: assert property (!diag_event |-> $stable(diagnostic_timestamp))
        else $error("stamp moved");
    AST_EVT: assert property (diag_event |-> (channel_error_summary
        & ~$past(channel_error_summary)) != 8'h00) else $error("event bad");
    AST_STEP: assert property ($changed(us_count) |-> us_count == $past(us_count) + 32'h1)
        else $error("count step");
    AST_TICK: assert property ($changed(us_count) |=> $stable(us_count) [*3] ##1
        $changed(us_count)) else $error("tick spacing");
    AST_ZERO: assert property ($rose(rst_n) |=> us_count == 32'h0) else $error("no zero");
endmodule // cdt_diag_props
bind cdt_channel_diag cdt_diag_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);
`default_nettype wire

/* tb/cdt_reader.sv */
// Record reader model on the backplane side
`default_nettype none
module cdt_reader (input wire logic ref_clk, input wire logic rst_n,
    output var logic [2:0] channel_select);
    timeunit 1ns; timeprecision 100ps;
    // Reads one channel record per cycle, walking all channels in turn
    always @(posedge ref_clk or negedge rst_n)
        if (!rst_n) channel_select <= 3'h0;
        else channel_select <= #1 channel_select + 3'h1;
endmodule // cdt_reader
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the channel diagnostic block
`default_nettype none
module tb_top;
    timeunit 1ns; timeprecision 100ps;
    logic ref_clk = 0, rst_n = 0, ev, ev_m;
    logic [7:0] pe = 0, wb = 0, en = 0, det, sum, md, sp, pp, wp, s, det_m, wq[$];
    logic [31:0] ts, us, us_m, usp, ts_m;
    logic [2:0] sel;
    int n_fail = 0, num_checks = 0, k = 0, cyc = 0;
    initial forever #2 ref_clk = ~ref_clk;
    cdt_reader u_cdt_reader (.ref_clk(ref_clk), .rst_n(rst_n), .channel_select(sel));
    cdt_channel_diag #(.TICK_CYCLES(4)) u_cdt_channel_diag (.ref_clk(ref_clk), .rst_n(rst_n),
        .param_error(pe), .wire_break_raw(wb), .wire_break_enable(en), .channel_select(sel),
        .channel_error_detail(det), .channel_error_summary(sum), .module_diag(md),
        .diagnostic_timestamp(ts), .diag_event(ev), .us_count(us));
    // Reference model; wire break reaches the summary four samples late
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            k = 0; sp = 0; pp = 0; wp = 0; ts_m = 0; us_m = 0; wq = '{0, 0, 0, 0, 0};
        end else begin
            k++; cyc++; usp = us_m; us_m = k / 4;
            wq.push_front(wb); void'(wq.pop_back());
            det_m = {3'h0, wp[sel], 3'h0, pp[sel]};
            s = pe | (wq[4] & en); ev_m = |(s & ~sp);
            if (ev_m) ts_m = usp;
            pp = pe; wp = wq[4] & en; sp = s;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Compare settled outputs mid-cycle; a hang counts as a mismatch
    always @(negedge ref_clk) if (rst_n && k > 0) begin
        chk(det, det_m);
        chk(sum, sp);
        chk(md, {4'h0, |sp, 3'h0});
        chk(ev, ev_m);
        chk(ts, ts_m);
        chk(us, us_m);
        if (cyc > 1000) begin n_fail++; give_verdict; end
    end
    task automatic run(input int n, input logic [7:0] w, input string nm);
        repeat (n) begin @(posedge ref_clk); #1 pe = 8'($urandom); wb = w; end
        $display("test %s done", nm);
    endtask
    // Enable changes only while the break input is quiet, so gating timing is moot
    initial begin
        void'($urandom(32'hd253));
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1;
        run(200, 8'h00, "param"); en = 8'($urandom);
        run(10, 8'h00, "enable"); run(30, 8'hFF, "break"); run(30, 8'h00, "clear");
        pe = 0; rst_n = 0; repeat (3) @(posedge ref_clk); #1 rst_n = 1;
        run(50, 8'h00, "again"); give_verdict;
    end
endmodule // tb_top
`default_nettype wire
